/* File: design/alrb_pkg.sv */
package alrb_pkg;
   // Bus widths
   localparam int AXI_ADDR_W = 15;
   localparam int DATA_W = 32;
   localparam int STRB_W = 4;
   localparam int WORD_W = AXI_ADDR_W - 2;
   // Decoder layout
   localparam int AREA_N = 7;
   localparam int OFS_W = 10;
   localparam int RD_DELAY = 3;
   localparam logic [AXI_ADDR_W-1:0] AREA_SPAN = 15'h1000;
   localparam logic [AREA_N-1:0][AXI_ADDR_W-1:0] AREA_BASE = {
      15'h6000, 15'h5000, 15'h4000, 15'h3000, 15'h2000, 15'h1000, 15'h0000
   };
   // Responses
   localparam logic [1:0] RESP_OKAY = 2'h0;

   typedef struct packed {
      logic awvalid;
      logic [AXI_ADDR_W-1:0] awaddr;
      logic wvalid;
      logic [DATA_W-1:0] wdata;
      logic [STRB_W-1:0] wstrb;
      logic bready;
      logic arvalid;
      logic [AXI_ADDR_W-1:0] araddr;
      logic rready;
   } alrb_axi_in_type;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0] rresp;
   } alrb_axi_out_type;

   typedef struct packed {
      logic [WORD_W-1:0] word_addr;
      logic write_strobe;
      logic [DATA_W-1:0] write_value;
      logic [STRB_W-1:0] byte_mask;
      logic read_request;
   } alrb_reg_cmd_type;

   typedef struct packed {
      logic [OFS_W-1:0] offset;
      logic [DATA_W-1:0] write_value;
      logic [STRB_W-1:0] byte_mask;
   } alrb_area_cmd_type;

   typedef enum logic [1:0] {
      OP_IDLE = 2'b00,
      OP_READ = 2'b01,
      OP_RESP = 2'b10,
      OP_WAIT = 2'b11
   } alrb_op_type;

   localparam alrb_axi_out_type AXI_OUT_RST = '0;
   localparam alrb_reg_cmd_type REG_CMD_RST = '0;
endpackage : alrb_pkg

/* File: design/alrb_register_decoder.sv */
`timescale 1ns/1ps
module alrb_register_decoder
   import alrb_pkg::*;
#(
   parameter int READ_DELAY = RD_DELAY
)
(
   // System
   input wire logic clk,
   input wire logic resetn,
   // Register side
   input alrb_reg_cmd_type reg_cmd,
   output logic reg_read_valid,
   output logic [DATA_W-1:0] reg_read_value,
   // Areas
   output logic [AREA_N-1:0] area_write_strobe,
   output logic [AREA_N-1:0] area_read_request,
   output alrb_area_cmd_type area_cmd,
   input wire logic [AREA_N-1:0][DATA_W-1:0] area_read_value
);
   if (READ_DELAY < 1 || READ_DELAY > 8) begin : g_bad_delay
      $error("READ_DELAY must be 1 to 8");
   end

   logic [AXI_ADDR_W-1:0] byte_addr;
   logic [AREA_N-1:0] hit;
   logic [READ_DELAY-1:0] pipe_q;
   logic [READ_DELAY-1:0] pipe_d;

   assign byte_addr = {reg_cmd.word_addr, 2'b00};

   // Area select from upper bits
   for (genvar i = 0; i < AREA_N; i++) begin : g_area
      assign hit[i] = (byte_addr >= AREA_BASE[i]) &&
                      (byte_addr < AREA_BASE[i] + AREA_SPAN);
      assign area_write_strobe[i] = hit[i] & reg_cmd.write_strobe;
      assign area_read_request[i] = hit[i] & reg_cmd.read_request;
   end

   // Lower bits go to every area
   assign area_cmd.offset = reg_cmd.word_addr[OFS_W-1:0];
   assign area_cmd.write_value = reg_cmd.write_value;
   assign area_cmd.byte_mask = reg_cmd.byte_mask;

   // Read mux, zero for unmapped space
   always_comb begin
      reg_read_value = '0;
      for (int i = 0; i < AREA_N; i++) begin
         if (hit[i]) begin
            reg_read_value = reg_read_value | area_read_value[i];
         end
      end
   end

   // Fixed read latency chain
   always_comb begin
      pipe_d = (READ_DELAY)'({pipe_q, reg_cmd.read_request});
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         pipe_q <= '0;
      end else begin
         pipe_q <= pipe_d;
      end
   end

   assign reg_read_valid = pipe_q[READ_DELAY-1];

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   read_delay_a: assert property (
      reg_cmd.read_request |-> ##3 reg_read_valid
   ) else $error("read valid not three cycles after request");

   valid_cause_a: assert property (
      reg_read_valid |-> $past(reg_cmd.read_request, 3)
   ) else $error("read valid without request");

   one_area_a: assert property (
      $onehot0(area_write_strobe | area_read_request)
   ) else $error("more than one area selected");

   tx_ram_area_a: assert property (
      area_write_strobe[3] |-> byte_addr[14:12] == 3'h3
   ) else $error("tx ram area outside its window");

   tx_ctrl_area_a: assert property (
      area_read_request[2] |-> (byte_addr >= 15'h2000 && byte_addr <= 15'h2FFF)
   ) else $error("tx control area outside its window");
endmodule : alrb_register_decoder

/* File: design/alrb_axi_to_register_top.sv */
// What this block does
// - Write address, write data, read address, read data handled by separate logic.
// - Write address and data cross domains into the register write port.
// - One register address serves writes and reads; they never overlap.
// - Register read data crosses back and appears on the AXI read channel.
// - Write strobe coincides with word address, write data and byte mask.
// - Four byte mask bits flag data bytes 0 to 3; only those written.
// - Read request is raised together with a valid address.
// - Address stays unchanged during a read until read valid arrives.
// - Upper address bits pick the target area; lower bits go to it.
// - Areas: core 0x0000, pattern 0x1000, tx control 0x2000.
// - Areas: tx ram 0x3000, rx control 0x4000, rx ram 0x5000, mac 0x6000.
// - Read valid is read request delayed through three flip-flops.
`timescale 1ns/1ps
module alrb_axi_to_register_top
   import alrb_pkg::*;
(
   // System
   input wire logic clk,
   input wire logic resetn,
   // CPU bus
   input wire logic cpu_clock,
   input alrb_axi_in_type axi_in,
   output alrb_axi_out_type axi_out,
   // Register areas
   output logic [AREA_N-1:0] area_write_strobe,
   output logic [AREA_N-1:0] area_read_request,
   output alrb_area_cmd_type area_cmd,
   input wire logic [AREA_N-1:0][DATA_W-1:0] area_read_value
);
   // Synchroniser state
   logic [2:0] cclk_q;
   logic [2:0] cclk_d;
   alrb_axi_in_type in_meta_q;
   alrb_axi_in_type in_sync_q;
   logic rise;
   logic fall;

   // Channel state
   alrb_axi_in_type samp_q;
   alrb_axi_in_type samp_d;
   alrb_axi_out_type out_q;
   alrb_axi_out_type out_d;
   logic aw_full_q;
   logic aw_full_d;
   logic [AXI_ADDR_W-1:0] aw_addr_q;
   logic [AXI_ADDR_W-1:0] aw_addr_d;
   logic w_full_q;
   logic w_full_d;
   logic [DATA_W-1:0] w_data_q;
   logic [DATA_W-1:0] w_data_d;
   logic [STRB_W-1:0] w_strb_q;
   logic [STRB_W-1:0] w_strb_d;
   logic ar_full_q;
   logic ar_full_d;
   logic [AXI_ADDR_W-1:0] ar_addr_q;
   logic [AXI_ADDR_W-1:0] ar_addr_d;

   // Operation state
   alrb_op_type op_q;
   alrb_op_type op_d;
   logic op_rd_q;
   logic op_rd_d;
   alrb_reg_cmd_type cmd_q;
   alrb_reg_cmd_type cmd_d;
   logic [DATA_W-1:0] rd_data_q;
   logic [DATA_W-1:0] rd_data_d;
   logic issue_wr;
   logic issue_rd;
   logic resp_done;
   logic reg_read_valid;
   logic [DATA_W-1:0] reg_read_value;

   // Bring cpu clock and bus into clk domain
   always_comb begin
      cclk_d = {cclk_q[1:0], cpu_clock};
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         cclk_q <= 3'h0;
         in_meta_q <= '0;
         in_sync_q <= '0;
      end else begin
         cclk_q <= cclk_d;
         in_meta_q <= axi_in;
         in_sync_q <= in_meta_q;
      end
   end

   assign rise = cclk_q[1] & ~cclk_q[2];
   assign fall = cclk_q[2] & ~cclk_q[1];

   assign resp_done = rise && (op_q == OP_WAIT) &&
                      ((out_q.bvalid && samp_q.bready) ||
                       (out_q.rvalid && samp_q.rready));

   // AXI channels, handshakes evaluated at cpu clock rise
   always_comb begin
      samp_d = samp_q;
      out_d = out_q;
      aw_full_d = aw_full_q;
      aw_addr_d = aw_addr_q;
      w_full_d = w_full_q;
      w_data_d = w_data_q;
      w_strb_d = w_strb_q;
      ar_full_d = ar_full_q;
      ar_addr_d = ar_addr_q;
      if (fall) begin
         samp_d = in_sync_q;
      end
      if (rise) begin
         if (samp_q.awvalid && out_q.awready) begin
            aw_full_d = 1'b1;
            aw_addr_d = samp_q.awaddr;
         end
         if (samp_q.wvalid && out_q.wready) begin
            w_full_d = 1'b1;
            w_data_d = samp_q.wdata;
            w_strb_d = samp_q.wstrb;
         end
         if (samp_q.arvalid && out_q.arready) begin
            ar_full_d = 1'b1;
            ar_addr_d = samp_q.araddr;
         end
         if (out_q.bvalid && samp_q.bready) begin
            out_d.bvalid = 1'b0;
         end
         if (out_q.rvalid && samp_q.rready) begin
            out_d.rvalid = 1'b0;
         end
         if (op_q == OP_RESP) begin
            if (op_rd_q) begin
               out_d.rvalid = 1'b1;
               out_d.rdata = rd_data_q;
               out_d.rresp = RESP_OKAY;
            end else begin
               out_d.bvalid = 1'b1;
               out_d.bresp = RESP_OKAY;
            end
         end
         out_d.awready = !aw_full_d;
         out_d.wready = !w_full_d;
         out_d.arready = !ar_full_d;
      end
      if (issue_wr) begin
         aw_full_d = 1'b0;
         w_full_d = 1'b0;
      end
      if (issue_rd) begin
         ar_full_d = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         samp_q <= '0;
         out_q <= AXI_OUT_RST;
         aw_full_q <= 1'b0;
         aw_addr_q <= '0;
         w_full_q <= 1'b0;
         w_data_q <= '0;
         w_strb_q <= '0;
         ar_full_q <= 1'b0;
         ar_addr_q <= '0;
      end else begin
         samp_q <= samp_d;
         out_q <= out_d;
         aw_full_q <= aw_full_d;
         aw_addr_q <= aw_addr_d;
         w_full_q <= w_full_d;
         w_data_q <= w_data_d;
         w_strb_q <= w_strb_d;
         ar_full_q <= ar_full_d;
         ar_addr_q <= ar_addr_d;
      end
   end

   assign axi_out = out_q;

   // Register port sequencing, one access at a time
   always_comb begin
      op_d = op_q;
      op_rd_d = op_rd_q;
      cmd_d = cmd_q;
      rd_data_d = rd_data_q;
      issue_wr = 1'b0;
      issue_rd = 1'b0;
      cmd_d.write_strobe = 1'b0;
      cmd_d.read_request = 1'b0;
      unique case (op_q)
         OP_IDLE: begin
            if (aw_full_q && w_full_q) begin
               issue_wr = 1'b1;
               cmd_d.word_addr = aw_addr_q[AXI_ADDR_W-1:2];
               cmd_d.write_value = w_data_q;
               cmd_d.byte_mask = w_strb_q;
               cmd_d.write_strobe = 1'b1;
               op_rd_d = 1'b0;
               op_d = OP_RESP;
            end else if (ar_full_q) begin
               issue_rd = 1'b1;
               cmd_d.word_addr = ar_addr_q[AXI_ADDR_W-1:2];
               cmd_d.read_request = 1'b1;
               op_rd_d = 1'b1;
               op_d = OP_READ;
            end
         end
         OP_READ: begin
            if (reg_read_valid) begin
               rd_data_d = reg_read_value;
               op_d = OP_RESP;
            end
         end
         OP_RESP: begin
            if (rise) begin
               op_d = OP_WAIT;
            end
         end
         OP_WAIT: begin
            if (resp_done) begin
               op_d = OP_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         op_q <= OP_IDLE;
         op_rd_q <= 1'b0;
         cmd_q <= REG_CMD_RST;
         rd_data_q <= '0;
      end else begin
         op_q <= op_d;
         op_rd_q <= op_rd_d;
         cmd_q <= cmd_d;
         rd_data_q <= rd_data_d;
      end
   end

   alrb_register_decoder #(
      .READ_DELAY(RD_DELAY)
   ) u_decoder (
      .clk(clk),
      .resetn(resetn),
      .reg_cmd(cmd_q),
      .reg_read_valid(reg_read_valid),
      .reg_read_value(reg_read_value),
      .area_write_strobe(area_write_strobe),
      .area_read_request(area_read_request),
      .area_cmd(area_cmd),
      .area_read_value(area_read_value)
   );

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   no_overlap_a: assert property (
      !(cmd_q.write_strobe && cmd_q.read_request)
   ) else $error("write and read issued together");

   addr_hold_a: assert property (
      (op_q == OP_READ) |=> $stable(cmd_q.word_addr)
   ) else $error("address moved during read");

   strobe_pulse_a: assert property (
      cmd_q.write_strobe |=> !cmd_q.write_strobe && (op_q == OP_RESP)
   ) else $error("write strobe not a single pulse");

   mask_match_a: assert property (
      cmd_q.write_strobe |-> cmd_q.byte_mask == $past(w_strb_q)
   ) else $error("byte mask differs from captured strobes");

   read_req_addr_a: assert property (
      cmd_q.read_request |-> cmd_q.word_addr == $past(ar_addr_q[AXI_ADDR_W-1:2])
   ) else $error("read request without its address");

   rdata_back_a: assert property (
      (op_q == OP_READ && reg_read_valid) |=> rd_data_q == $past(reg_read_value)
   ) else $error("read data not captured");

   bresp_okay_a: assert property (
      (op_q == OP_RESP && !op_rd_q && rise) |=> out_q.bvalid && out_q.bresp == RESP_OKAY
   ) else $error("write response missing");

   read_sync_a: assert property (
      (op_q == OP_RESP && op_rd_q && rise) |=> out_q.rvalid && out_q.rdata == rd_data_q
   ) else $error("read data not presented");

   b_hold_a: assert property (
      (out_q.bvalid && !(rise && samp_q.bready)) |=> out_q.bvalid
   ) else $error("write response dropped early");

   r_hold_a: assert property (
      (out_q.rvalid && !(rise && samp_q.rready)) |=> out_q.rvalid && $stable(out_q.rdata)
   ) else $error("read data dropped or changed early");

   req_pulse_a: assert property (
      cmd_q.read_request |=> !cmd_q.read_request && (op_q == OP_READ)
   ) else $error("read request not a single pulse");

   wr_seen_c: cover property (cmd_q.write_strobe);
   rd_seen_c: cover property (cmd_q.read_request ##3 reg_read_valid);
   b_done_c: cover property (out_q.bvalid ##1 !out_q.bvalid);
   r_done_c: cover property (out_q.rvalid ##1 !out_q.rvalid);
endmodule : alrb_axi_to_register_top

/* File: sim/alrb_area_model.sv */
`timescale 1ns/1ps
module alrb_area_model
   import alrb_pkg::*;
(
   // System
   input wire logic clk,
   // Register areas
   input wire logic [AREA_N-1:0] area_write_strobe,
   input wire logic [AREA_N-1:0] area_read_request,
   input alrb_area_cmd_type area_cmd,
   output logic [AREA_N-1:0][DATA_W-1:0] area_read_value
);
   logic [DATA_W-1:0] mem [AREA_N][1024];
   logic [2:0][AREA_N-1:0] pipe = '0;
   logic [DATA_W-1:0] noise = 32'h0;

   initial begin
      foreach (mem[a, w]) mem[a][w] = 32'h0;
   end

   // Store enabled bytes, track read latency
   always @(posedge clk) begin
      pipe <= {pipe[1:0], area_read_request};
      noise <= noise + 32'h9E3779B9;
      for (int a = 0; a < AREA_N; a++) begin
         for (int b = 0; b < STRB_W; b++) begin
            if (area_write_strobe[a] && area_cmd.byte_mask[b]) begin
               mem[a][area_cmd.offset][8*b +: 8] <= area_cmd.write_value[8*b +: 8];
            end
         end
      end
   end

   // Data valid only three clocks after the request, else noise
   always_comb begin
      for (int a = 0; a < AREA_N; a++) begin
         area_read_value[a] = pipe[2][a] ? mem[a][area_cmd.offset] : noise;
      end
   end
endmodule : alrb_area_model

/* File: sim/test_axi_lite_register_bridge.sv */
`timescale 1ns/1ps
module test_axi_lite_register_bridge;
   import alrb_pkg::*;
   logic clk, resetn, cpu_clock;
   alrb_axi_in_type axi_in;
   alrb_axi_out_type axi_out;
   logic [AREA_N-1:0] area_write_strobe, area_read_request;
   alrb_area_cmd_type area_cmd;
   logic [AREA_N-1:0][DATA_W-1:0] area_read_value;
   int miscompares, n_compared, seed, n_wr, n_rd;
   logic [2:0] wr_area, rd_area;
   logic [OFS_W-1:0] wr_ofs, rd_ofs;
   logic [DATA_W-1:0] wr_val, rdat;
   logic [DATA_W-1:0] exp_mem [8][1024];
   logic [STRB_W-1:0] wr_mask;

   alrb_axi_to_register_top i_dut (.clk(clk), .resetn(resetn), .cpu_clock(cpu_clock),
      .axi_in(axi_in), .axi_out(axi_out), .area_write_strobe(area_write_strobe),
      .area_read_request(area_read_request), .area_cmd(area_cmd),
      .area_read_value(area_read_value));

   alrb_area_model i_area (.clk(clk), .area_write_strobe(area_write_strobe),
      .area_read_request(area_read_request), .area_cmd(area_cmd),
      .area_read_value(area_read_value));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   initial begin
      cpu_clock = 1'b0;
      #1;
      forever #80 cpu_clock = ~cpu_clock;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] expected);
      n_compared++;
      if (seen !== expected) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, seen, expected);
      end
   endtask : check

   task automatic test_done;
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : test_done

   task automatic tick(inout int n);
      @(posedge cpu_clock);
      n++;
      if (n > 40) begin
         miscompares++;
         $display("unexpected at %0t: handshake wait ran out", $time);
         test_done();
      end
   endtask : tick

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv,
      input logic [3:0] m);
      for (int b = 0; b < 4; b++) begin
         if (m[b]) old[8*b +: 8] = nv[8*b +: 8];
      end
      return old;
   endfunction : merge

   // Area side monitor
   always @(posedge clk) begin
      if (resetn) begin
         if (|area_write_strobe && |area_read_request) check(32'h1, 32'h0);
         if (!$onehot0(area_write_strobe)) check(32'h0, 32'h1);
         if (!$onehot0(area_read_request)) check(32'h0, 32'h1);
         for (int a = 0; a < AREA_N; a++) begin
            if (area_write_strobe[a]) begin
               wr_area = 3'(a);
               wr_ofs = area_cmd.offset;
               wr_val = area_cmd.write_value;
               wr_mask = area_cmd.byte_mask;
               n_wr++;
            end
            if (area_read_request[a]) begin
               rd_area = 3'(a);
               rd_ofs = area_cmd.offset;
               n_rd++;
            end
         end
      end
   end

   task automatic wr_check(input logic [14:0] addr, input logic [31:0] d, input logic [3:0] s);
      int n, w0;
      logic aw_ok, w_ok;
      n = 0;
      w0 = n_wr;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge cpu_clock);
      #1;
      axi_in.awvalid = 1'b1;
      axi_in.awaddr = addr;
      axi_in.wvalid = 1'b1;
      axi_in.wdata = d;
      axi_in.wstrb = s;
      while (!(aw_ok && w_ok)) begin
         tick(n);
         if (axi_in.awvalid && axi_out.awready === 1'b1) aw_ok = 1'b1;
         if (axi_in.wvalid && axi_out.wready === 1'b1) w_ok = 1'b1;
         #1;
         if (aw_ok) axi_in.awvalid = 1'b0;
         if (w_ok) axi_in.wvalid = 1'b0;
      end
      axi_in.bready = 1'b1;
      do tick(n); while (axi_out.bvalid !== 1'b1);
      check(axi_out.bresp, RESP_OKAY);
      #1;
      axi_in.bready = 1'b0;
      check(n_wr - w0, addr[14:12] == 3'h7 ? 0 : 1);
      if (addr[14:12] != 3'h7) begin
         check(wr_area, addr[14:12]);
         check(wr_ofs, addr[11:2]);
         check(wr_val, d);
         check(wr_mask, s);
         exp_mem[addr[14:12]][addr[11:2]] = merge(exp_mem[addr[14:12]][addr[11:2]], d, s);
      end
   endtask : wr_check

   task automatic rd_check(input logic [14:0] addr);
      int n, r0;
      n = 0;
      r0 = n_rd;
      @(posedge cpu_clock);
      #1;
      axi_in.arvalid = 1'b1;
      axi_in.araddr = addr;
      do tick(n); while (axi_out.arready !== 1'b1);
      #1;
      axi_in.arvalid = 1'b0;
      axi_in.rready = 1'b1;
      do tick(n); while (axi_out.rvalid !== 1'b1);
      rdat = axi_out.rdata;
      check(axi_out.rresp, RESP_OKAY);
      #1;
      axi_in.rready = 1'b0;
      check(rdat, exp_mem[addr[14:12]][addr[11:2]]);
      check(n_rd - r0, addr[14:12] == 3'h7 ? 0 : 1);
      if (addr[14:12] != 3'h7) begin
         check(rd_area, addr[14:12]);
         check(rd_ofs, addr[11:2]);
      end
   endtask : rd_check

   initial begin
      logic [14:0] ad;
      seed = 65553;
      axi_in = '0;
      resetn = 1'b0;
      miscompares = 0;
      n_compared = 0;
      n_wr = 0;
      n_rd = 0;
      foreach (exp_mem[a, w]) exp_mem[a][w] = 32'h0;
      repeat (12) @(posedge clk);
      #1;
      check({axi_out.bvalid, axi_out.rvalid, area_write_strobe, area_read_request}, 0);
      resetn = 1'b1;
      // Every area, first and last word
      for (int a = 0; a < 8; a++) begin
         wr_check(15'(a * 4096), 32'hA5A50000 | a, 4'hF);
         wr_check(15'(a * 4096 + 4092), 32'h5A5A0F0F ^ a, 4'hF);
         rd_check(15'(a * 4096));
         rd_check(15'(a * 4096 + 4095));
      end
      // Every byte mask
      for (int m = 0; m < 16; m++) begin
         wr_check(15'h5010, $random(seed), 4'(m));
         rd_check(15'h5010);
      end
      // Write and read pending together
      fork
         wr_check(15'h3020, 32'hDEADBEEF, 4'hF);
         rd_check(15'h1000);
      join
      rd_check(15'h3020);
      // Random traffic
      repeat (60) begin
         ad = 15'($random(seed)) & 15'h703F;
         if ($random(seed) & 1) begin
            wr_check(ad, $random(seed), 4'($random(seed)));
         end else begin
            rd_check(ad);
         end
      end
      test_done();
   end
endmodule : test_axi_lite_register_bridge
